// ===== hdrap_pkg.sv
package hdrap_pkg;

	// ==========================================
	// Bus and memory widths
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int RAM_ADDR_W = 13;
	localparam int RAM_DATA_W = 16;
	localparam int RAM_DEPTH  = 8192;

	// ==========================================
	// Register offsets
	localparam logic [7:0] OFF_DATA_LOW   = 8'h18;
	localparam logic [7:0] OFF_DATA_HIGH  = 8'h19;
	localparam logic [7:0] OFF_ADDR_LOW   = 8'h1C;
	localparam logic [7:0] OFF_ACCESS_CTL = 8'h1D;
	localparam logic [7:0] OFF_STATUS     = 8'h1F;
	localparam logic [7:0] OFF_EVT_STATUS = 8'h10;
	localparam logic [7:0] OFF_EVT_CLEAR  = 8'h11;
	localparam logic [7:0] OFF_EVT_ENABLE = 8'h12;

	// ==========================================
	// Field positions in the access control register
	localparam int CTL_NIB_LSB = 0;
	localparam int CTL_NIB_MSB = 3;
	localparam int CTL_CR_BIT  = 4;
	localparam int CTL_WR_BIT  = 5;
	localparam int CTL_TOP_BIT = 6;
	localparam int CTL_GO_BIT  = 7;

	// Field position of the new-status flag
	localparam int STAT_STATUS_CHANGE_FLAG_BIT = 3;

	// Event bit positions
	localparam int EVT_W         = 2;
	localparam int EVT_DONE_BIT  = 0;
	localparam int EVT_CREAD_BIT = 1;

	// ==========================================
	// Reset values
	localparam logic [7:0]       RST_BYTE = 8'h00;
	localparam logic [3:0]       RST_NIB  = 4'h0;
	localparam logic             RST_BIT  = 1'b0;
	localparam logic [EVT_W-1:0] RST_EVT  = 2'h0;

	// ==========================================
	// Access engine states
	typedef enum logic [1:0] {
		HDRAP_IDLE   = 2'b00,
		HDRAP_RUN    = 2'b01,
		HDRAP_FINISH = 2'b10
	} hdrap_state_t;

endpackage

// ===== hdrap_ram.sv
`timescale 1ns/1ps
module hdrap_ram (
	// Clock
	input  wire logic                                clk,
	// Access port
	input  wire logic                                en,
	input  wire logic                                we,
	input  wire logic [hdrap_pkg::RAM_ADDR_W-1:0]    addr,
	input  wire logic [hdrap_pkg::RAM_DATA_W-1:0]    wdata,
	output logic      [hdrap_pkg::RAM_DATA_W-1:0]    rdata
);

	// ==========================================
	// Storage
	logic [hdrap_pkg::RAM_DATA_W-1:0] mem_q [hdrap_pkg::RAM_DEPTH];
	logic [hdrap_pkg::RAM_DATA_W-1:0] rdata_q;

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem_q[addr] <= wdata;
		end
		if (en && !we) begin
			rdata_q <= mem_q[addr];
		end
	end

	assign rdata = rdata_q;

endmodule // hdrap_ram

// ===== hdrap_top.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module hdrap_top (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	// Register port
	input  wire logic [hdrap_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [hdrap_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [hdrap_pkg::DATA_W-1:0]  reg_rdata,
	// Interrupt
	output logic                               irq
);

	// ==========================================
	// Register state
	logic [7:0]                  data_low_q,  data_low_d;
	logic [7:0]                  data_high_q, data_high_d;
	logic [7:0]                  addr_low_q,  addr_low_d;
	logic [3:0]                  addr_nib_q,  addr_nib_d;
	logic                        addr_top_q,  addr_top_d;
	logic                        wr_sel_q,    wr_sel_d;
	logic                        cread_q,     cread_d;
	logic                        go_q,        go_d;
	logic                        status_change_flag_q,      status_change_flag_d;
	logic [hdrap_pkg::EVT_W-1:0] evt_q,       evt_d;
	logic [hdrap_pkg::EVT_W-1:0] evt_en_q,    evt_en_d;
	logic [7:0]                  rdata_q,     rdata_d;
	logic                        irq_q,       irq_d;

	// Access engine state
	hdrap_pkg::hdrap_state_t                 state_q, state_d;
	logic                                    op_wr_q, op_wr_d;
	logic                                    op_cr_q, op_cr_d;
	logic [hdrap_pkg::RAM_ADDR_W-1:0]        op_addr_q, op_addr_d;

	// RAM port
	logic                                    ram_en;
	logic                                    ram_we;
	logic [hdrap_pkg::RAM_DATA_W-1:0]        ram_rdata;

	// Decoded strobes
	logic wr_data_low;
	logic wr_data_high;
	logic wr_addr_low;
	logic wr_ctl;
	logic wr_stat;
	logic wr_evt_clr;
	logic wr_evt_en;
	logic finish;
	logic [hdrap_pkg::EVT_W-1:0] evt_set;

	// ==========================================
	// Address decode
	always_comb begin
		wr_data_low  = 1'b0;
		wr_data_high = 1'b0;
		wr_addr_low  = 1'b0;
		wr_ctl       = 1'b0;
		wr_stat      = 1'b0;
		wr_evt_clr   = 1'b0;
		wr_evt_en    = 1'b0;
		if (reg_wr) begin
			if (reg_addr == hdrap_pkg::OFF_DATA_LOW) begin
				wr_data_low = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_DATA_HIGH) begin
				wr_data_high = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_ADDR_LOW) begin
				wr_addr_low = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_ACCESS_CTL) begin
				wr_ctl = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_STATUS) begin
				wr_stat = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_EVT_CLEAR) begin
				wr_evt_clr = 1'b1;
			end else if (reg_addr == hdrap_pkg::OFF_EVT_ENABLE) begin
				wr_evt_en = 1'b1;
			end
		end
	end

	// ==========================================
	// Access engine
	always_comb begin
		state_d   = state_q;
		op_wr_d   = op_wr_q;
		op_cr_d   = op_cr_q;
		op_addr_d = op_addr_q;
		ram_en    = 1'b0;
		ram_we    = 1'b0;
		finish    = 1'b0;
		case (state_q)
			hdrap_pkg::HDRAP_IDLE: begin
				if (go_q) begin
					state_d   = hdrap_pkg::HDRAP_RUN;
					op_wr_d   = wr_sel_q;
					op_cr_d   = 1'b0;
					op_addr_d = {addr_top_q, addr_nib_q, addr_low_q};
				end else if (cread_q) begin
					state_d   = hdrap_pkg::HDRAP_RUN;
					op_wr_d   = 1'b0;
					op_cr_d   = 1'b1;
					op_addr_d = {addr_top_q, addr_nib_q, addr_low_q};
				end
			end
			hdrap_pkg::HDRAP_RUN: begin
				ram_en  = 1'b1;
				ram_we  = op_wr_q;
				state_d = hdrap_pkg::HDRAP_FINISH;
			end
			hdrap_pkg::HDRAP_FINISH: begin
				finish  = 1'b1;
				state_d = hdrap_pkg::HDRAP_IDLE;
			end
			default: begin
				state_d = hdrap_pkg::HDRAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= hdrap_pkg::HDRAP_IDLE;
			op_wr_q   <= hdrap_pkg::RST_BIT;
			op_cr_q   <= hdrap_pkg::RST_BIT;
			op_addr_q <= '0;
		end else begin
			state_q   <= state_d;
			op_wr_q   <= op_wr_d;
			op_cr_q   <= op_cr_d;
			op_addr_q <= op_addr_d;
		end
	end

	// ==========================================
	// Internal RAM
	hdrap_ram u_ram (
		.clk   (clk),
		.en    (ram_en),
		.we    (ram_we),
		.addr  (op_addr_q),
		.wdata ({data_high_q, data_low_q}),
		.rdata (ram_rdata)
	);

	// ==========================================
	// Host registers
	always_comb begin
		data_low_d  = data_low_q;
		data_high_d = data_high_q;
		addr_low_d  = addr_low_q;
		addr_nib_d  = addr_nib_q;
		addr_top_d  = addr_top_q;
		wr_sel_d    = wr_sel_q;
		cread_d     = cread_q;
		go_d        = go_q;
		status_change_flag_d      = status_change_flag_q;
		if (wr_data_low) begin
			data_low_d = reg_wdata;
		end
		if (wr_data_high) begin
			data_high_d = reg_wdata;
		end
		if (wr_addr_low) begin
			addr_low_d = reg_wdata;
		end
		if (finish && !op_cr_q) begin
			go_d = 1'b0;
		end
		if (wr_ctl) begin
			addr_nib_d = reg_wdata[hdrap_pkg::CTL_NIB_MSB:hdrap_pkg::CTL_NIB_LSB];
			addr_top_d = reg_wdata[hdrap_pkg::CTL_TOP_BIT];
			wr_sel_d   = reg_wdata[hdrap_pkg::CTL_WR_BIT];
			cread_d    = reg_wdata[hdrap_pkg::CTL_CR_BIT];
			if (reg_wdata[hdrap_pkg::CTL_GO_BIT]) begin
				go_d = 1'b1;
			end
		end
		if (finish && !op_wr_q) begin
			data_low_d  = ram_rdata[7:0];
			data_high_d = ram_rdata[15:8];
		end
		if (wr_stat && !reg_wdata[hdrap_pkg::STAT_STATUS_CHANGE_FLAG_BIT]) begin
			status_change_flag_d = 1'b0;
		end
		if (finish) begin
			status_change_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_low_q  <= hdrap_pkg::RST_BYTE;
			data_high_q <= hdrap_pkg::RST_BYTE;
			addr_low_q  <= hdrap_pkg::RST_BYTE;
			addr_nib_q  <= hdrap_pkg::RST_NIB;
			addr_top_q  <= hdrap_pkg::RST_BIT;
			wr_sel_q    <= hdrap_pkg::RST_BIT;
			cread_q     <= hdrap_pkg::RST_BIT;
			go_q        <= hdrap_pkg::RST_BIT;
			status_change_flag_q      <= hdrap_pkg::RST_BIT;
		end else begin
			data_low_q  <= data_low_d;
			data_high_q <= data_high_d;
			addr_low_q  <= addr_low_d;
			addr_nib_q  <= addr_nib_d;
			addr_top_q  <= addr_top_d;
			wr_sel_q    <= wr_sel_d;
			cread_q     <= cread_d;
			go_q        <= go_d;
			status_change_flag_q      <= status_change_flag_d;
		end
	end

	// ==========================================
	// Event status and interrupt
	always_comb begin
		evt_set = '0;
		evt_set[hdrap_pkg::EVT_DONE_BIT]  = finish && !op_cr_q;
		evt_set[hdrap_pkg::EVT_CREAD_BIT] = finish && op_cr_q;
		evt_d    = evt_q;
		evt_en_d = evt_en_q;
		if (wr_evt_clr) begin
			evt_d = evt_q & ~reg_wdata[hdrap_pkg::EVT_W-1:0];
		end
		evt_d = evt_d | evt_set;
		if (wr_evt_en) begin
			evt_en_d = reg_wdata[hdrap_pkg::EVT_W-1:0];
		end
		irq_d = |(evt_d & evt_en_d);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_q    <= hdrap_pkg::RST_EVT;
			evt_en_q <= hdrap_pkg::RST_EVT;
			irq_q    <= hdrap_pkg::RST_BIT;
		end else begin
			evt_q    <= evt_d;
			evt_en_q <= evt_en_d;
			irq_q    <= irq_d;
		end
	end

	// ==========================================
	// Read data
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			if (reg_addr == hdrap_pkg::OFF_DATA_LOW) begin
				rdata_d = data_low_q;
			end else if (reg_addr == hdrap_pkg::OFF_DATA_HIGH) begin
				rdata_d = data_high_q;
			end else if (reg_addr == hdrap_pkg::OFF_ADDR_LOW) begin
				rdata_d = addr_low_q;
			end else if (reg_addr == hdrap_pkg::OFF_ACCESS_CTL) begin
				rdata_d = {go_q, addr_top_q, wr_sel_q, cread_q, addr_nib_q};
			end else if (reg_addr == hdrap_pkg::OFF_STATUS) begin
				rdata_d[hdrap_pkg::STAT_STATUS_CHANGE_FLAG_BIT] = status_change_flag_q;
			end else if (reg_addr == hdrap_pkg::OFF_EVT_STATUS) begin
				rdata_d[hdrap_pkg::EVT_W-1:0] = evt_q;
			end else if (reg_addr == hdrap_pkg::OFF_EVT_ENABLE) begin
				rdata_d[hdrap_pkg::EVT_W-1:0] = evt_en_q;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= hdrap_pkg::RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

endmodule // hdrap_top

// ===== hdrap_host.sv
`timescale 1ns/1ps
module hdrap_host (
	// Clock
	input  wire logic                         clk,
	// Register port
	output logic      [hdrap_pkg::ADDR_W-1:0] reg_addr,
	output logic      [hdrap_pkg::DATA_W-1:0] reg_wdata,
	output logic                              reg_wr,
	output logic                              reg_rd,
	input  wire logic [hdrap_pkg::DATA_W-1:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// ==========================================
	// Bus cycles
	// fields held per strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata;
	endtask
endmodule // hdrap_host

// ===== hdrap_sva.sv
`timescale 1ns/1ps
module hdrap_sva (
	// Clock and reset
	input wire logic                         clk,
	input wire logic                         arst_n,
	// Register port
	input wire logic [hdrap_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [hdrap_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                         reg_wr,
	input wire logic                         reg_rd,
	input wire logic [hdrap_pkg::DATA_W-1:0] reg_rdata,
	// Interrupt
	input wire logic                         irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire wr_ctl = reg_wr && reg_addr == 8'h1D;
	wire rd_ctl = reg_rd && reg_addr == 8'h1D;

	// ==========================================
	// Properties
	a_go_busy: assert property (wr_ctl && reg_wdata[7] ##2 rd_ctl |=> reg_rdata[7])
		else $error("go not standing during access");
	a_go_clear: assert property (wr_ctl && reg_wdata[7] ##[4:6] rd_ctl |=> !reg_rdata[7])
		else $error("go not cleared after access");
	a_status_change_flag_done: assert property (wr_ctl && reg_wdata[7] ##[4:8] reg_rd && reg_addr == 8'h1F |=> reg_rdata[3])
		else $error("new status not set after access");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_addr_rb: assert property (reg_wr && reg_addr == 8'h1C ##2 reg_rd && reg_addr == 8'h1C
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("low address readback wrong");
	a_ctl_rb: assert property (wr_ctl && !reg_wdata[7] ##2 rd_ctl
		|=> ((reg_rdata ^ $past(reg_wdata, 3)) & 8'h7F) == 8'h00)
		else $error("control readback wrong");
	a_irq_mask: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata == 8'h00 |-> ##2 !irq)
		else $error("interrupt not masked");
	a_irq_done: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata[0] ##[1:8] wr_ctl && reg_wdata[7]
		|-> ##5 irq)
		else $error("interrupt missing after access");
endmodule // hdrap_sva

bind hdrap_top hdrap_sva u_sva (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ===== tb_host_dsp_ram_access_port.sv
`timescale 1ns/1ps
module tb_host_dsp_ram_access_port;
	logic                         clk;
	logic                         arst_n;
	logic [hdrap_pkg::ADDR_W-1:0] reg_addr;
	logic [hdrap_pkg::DATA_W-1:0] reg_wdata;
	logic                         reg_wr;
	logic                         reg_rd;
	logic [hdrap_pkg::DATA_W-1:0] reg_rdata;
	logic                         irq;
	logic [7:0]                   d;
	int                           fail_count;
	int                           total_checks;
	int                           cyc;

	hdrap_top DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	hdrap_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================
	// Helpers
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic acc(input logic [12:0] a, input logic ws, input logic [15:0] w);
		int n;
		host.wr(8'h18, w[7:0]);
		host.wr(8'h19, w[15:8]);
		host.wr(8'h1C, a[7:0]);
		host.wr(8'h1D, {1'b1, a[12], ws, 1'b0, a[11:8]});
		n = 0;
		d = 8'hFF;
		while (d[7] && n < 20) begin
			host.rd(8'h1D, d);
			n++;
		end
		chk("ctl", d, {1'b0, a[12], ws, 1'b0, a[11:8]});
		host.rd(8'h1F, d);
		chk("status_change_flag", d & 8'h08, 8'h08);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] offs [8] = '{8'h18, 8'h19, 8'h1C, 8'h1D, 8'h1F, 8'h10, 8'h12, 8'h00};
		foreach (offs[i]) begin
			host.rd(offs[i], d);
			chk("reset", d, 8'h00);
		end
		host.wr(8'h1C, 8'h5A);
		host.rd(8'h1C, d);
		chk("addr", d, 8'h5A);
		$display("t_regs done");
	endtask

	task automatic t_ram();
		logic [12:0] at [4] = '{13'h1FFF, 13'h0FFF, 13'h1000, 13'h0100};
		foreach (at[i])
			acc(at[i], 1'b1, 16'hA000 ^ {3'h0, at[i]});
		foreach (at[i]) begin
			acc(at[i], 1'b0, 16'h0000);
			host.rd(8'h18, d);
			chk("low", d, 8'h00 ^ at[i][7:0]);
			host.rd(8'h19, d);
			chk("high", d, 8'hA0 ^ {3'h0, at[i][12:8]});
		end
		host.wr(8'h1F, 8'h08);
		host.rd(8'h1F, d);
		chk("status_change_flag", d, 8'h08);
		host.wr(8'h1F, 8'h00);
		host.rd(8'h1F, d);
		chk("status_change_flag", d, 8'h00);
		$display("t_ram done");
	endtask

	task automatic t_cont();
		acc(13'h0ABC, 1'b1, 16'h1234);
		host.wr(8'h18, 8'h00);
		host.wr(8'h19, 8'h00);
		host.wr(8'h1F, 8'h00);
		host.wr(8'h1D, 8'h1A);
		host.rd(8'h1D, d);
		chk("ctl", d, 8'h1A);
		repeat (10) @(posedge clk);
		host.rd(8'h18, d);
		chk("cont", d, 8'h34);
		host.rd(8'h19, d);
		chk("cont", d, 8'h12);
		host.rd(8'h1F, d);
		chk("status_change_flag", d, 8'h08);
		host.wr(8'h1D, 8'h00);
		repeat (6) @(posedge clk);
		host.wr(8'h1F, 8'h00);
		host.wr(8'h11, 8'h03);
		$display("t_cont done");
	endtask

	task automatic t_irq();
		host.wr(8'h12, 8'h01);
		acc(13'h0001, 1'b1, 16'hBEEF);
		chk("irq", {7'h00, irq}, 8'h01);
		host.rd(8'h10, d);
		chk("evt", d, 8'h01);
		host.wr(8'h12, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq", {7'h00, irq}, 8'h00);
		host.wr(8'h12, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq", {7'h00, irq}, 8'h01);
		host.wr(8'h11, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq", {7'h00, irq}, 8'h00);
		host.rd(8'h10, d);
		chk("evt", d, 8'h00);
		$display("t_irq done");
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		arst_n = 1'b0;
		fail_count = 0;
		total_checks = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_ram();
		t_cont();
		t_irq();
		conclude();
	end
endmodule // tb_host_dsp_ram_access_port
